// File: core/isw_pkg.sv
// package: constants and types for the two-wire write-only slave front end
package isw_pkg;

  // ----------------------------------------------------------------
  // protocol constants
  // ----------------------------------------------------------------
  localparam logic [4:0] ISW_UPPER_ADDR_DEF = 5'h0A; // arbitrary value
  localparam logic [2:0] ISW_OP_MARGIN = 3'h1;
  localparam logic [2:0] ISW_OP_WDOG = 3'h3;
  localparam logic [4:0] ISW_VALUE_LEAD = 5'h00;
  localparam logic [3:0] ISW_BITS_PER_BYTE = 4'h8;
  localparam logic [0:0] ISW_DIR_WRITE = 1'h0;
  localparam int ISW_OSC_HALF_CYC = 16;
  localparam int ISW_FIFO_DEPTH = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ISW_IDLE = 3'b000,
    ISW_ADDR = 3'b001,
    ISW_ACK = 3'b010,
    ISW_DATA = 3'b011,
    ISW_IGNORE = 3'b100
  } isw_state_type;

  typedef struct packed {
    logic [2:0] op;
    logic [4:0] value;
  } isw_cmd_type;

endpackage

// File: core/isw_fifo.sv
// two-entry command buffer with valid/ready on both sides
`timescale 1ns/1ns
module isw_fifo
  import isw_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = ISW_FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign o_ready = (count != (PW + 1)'(DEPTH));
  assign o_valid = (count != '0);
  assign o_data = mem[rd_ptr];
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// File: core/isw_slave.sv
// write-only two-wire slave front end with strap address and sync pin control
`timescale 1ns/1ns
module isw_slave
  import isw_pkg::*;
#(
  parameter logic [4:0] UPPER_ADDR = ISW_UPPER_ADDR_DEF,
  parameter int OSC_HALF_CYC = ISW_OSC_HALF_CYC
) (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RESET_N,
  // two-wire bus
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA_OUT,
  output logic O_SDA_OE,
  // straps
  input wire logic I_UPPER_ID_STRAP,
  input wire logic I_LOWER_ID_STRAP,
  // oscillator sync pin
  input wire logic I_OSC_SYNC_IN,
  output logic O_OSC_SYNC_OUT,
  output logic O_OSC_SYNC_OE,
  output logic O_OSC_CLK,
  // command stream
  output logic O_CMD_VALID,
  output isw_cmd_type O_CMD_DATA,
  input wire logic I_CMD_READY
);

  // ----------------------------------------------------------------
  // input synchronisers and edge detection
  // ----------------------------------------------------------------
  logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
  logic ups_m, ups_s, lws_m, lws_s, osi_m, osi_s;
  logic scl_rise, scl_fall, start_det, stop_det;

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      {scl_m, scl_s, scl_q, sda_m, sda_s, sda_q} <= 6'h3F;
      {osi_m, osi_s} <= 2'h0;
    end else begin
      scl_m <= I_SCL;
      scl_s <= scl_m;
      scl_q <= scl_s;
      sda_m <= I_SDA;
      sda_s <= sda_m;
      sda_q <= sda_s;
      osi_m <= I_OSC_SYNC_IN;
      osi_s <= osi_m;
    end
  end

  // strap synchronisers run through reset, so straps are settled at release
  always_ff @(posedge I_CORE_CLK) begin
    ups_m <= I_UPPER_ID_STRAP;
    ups_s <= ups_m;
    lws_m <= I_LOWER_ID_STRAP;
    lws_s <= lws_m;
  end

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det = scl_s & scl_q & ~sda_q & sda_s;

  // ----------------------------------------------------------------
  // strap capture after reset release
  // ----------------------------------------------------------------
  logic strap_done, id_bit_high, id_bit_low;
  logic [6:0] own_addr;

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      strap_done <= 1'b0;
      id_bit_high <= 1'b1;
      id_bit_low <= 1'b1;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      id_bit_high <= ups_s;
      id_bit_low <= lws_s;
    end
  end

  assign own_addr = {UPPER_ADDR, id_bit_high, id_bit_low};

  // ----------------------------------------------------------------
  // oscillator sync pin
  // ----------------------------------------------------------------
  localparam int DW = $clog2(OSC_HALF_CYC + 1);
  logic [DW-1:0] div_cnt;
  logic div_clk;

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      div_cnt <= '0;
      div_clk <= 1'b0;
      O_OSC_SYNC_OUT <= 1'b0;
      O_OSC_SYNC_OE <= 1'b0;
      O_OSC_CLK <= 1'b0;
    end else begin
      if (div_cnt == DW'(OSC_HALF_CYC - 1)) begin
        div_cnt <= '0;
        div_clk <= ~div_clk;
      end else begin
        div_cnt <= div_cnt + 1'b1;
      end
      O_OSC_SYNC_OE <= strap_done & id_bit_high;
      O_OSC_SYNC_OUT <= div_clk;
      O_OSC_CLK <= id_bit_high ? div_clk : osi_s;
    end
  end

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  isw_state_type state;
  logic [7:0] shreg;
  logic [3:0] bit_cnt;
  logic byte_end, addr_hit, fifo_in_ready, fifo_in_valid;
  logic armed, exec, leading, accept;
  logic [2:0] armed_op;
  isw_cmd_type rx_cmd;

  assign rx_cmd = isw_cmd_type'(shreg);
  assign byte_end = scl_fall & (bit_cnt == ISW_BITS_PER_BYTE);
  assign addr_hit = (shreg == {own_addr, ISW_DIR_WRITE});
  assign exec = armed & (rx_cmd.op == armed_op);
  assign leading = ((rx_cmd.op == ISW_OP_MARGIN) || (rx_cmd.op == ISW_OP_WDOG)) && (rx_cmd.value == ISW_VALUE_LEAD);
  assign accept = ~exec | fifo_in_ready;
  assign fifo_in_valid = (state == ISW_DATA) & byte_end & exec;

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state <= ISW_IDLE;
      shreg <= 8'h00;
      bit_cnt <= 4'h0;
      O_SDA_OE <= 1'b0;
      O_SDA_OUT <= 1'b0;
    end else if (stop_det) begin
      state <= ISW_IDLE;
      O_SDA_OE <= 1'b0;
    end else if (start_det) begin
      state <= ISW_ADDR;
      bit_cnt <= 4'h0;
      O_SDA_OE <= 1'b0;
    end else begin
      case (state)
        ISW_ADDR, ISW_DATA: begin
          if (scl_rise && bit_cnt != ISW_BITS_PER_BYTE) begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_end && state == ISW_ADDR) begin
            state <= addr_hit ? ISW_ACK : ISW_IGNORE;
            O_SDA_OE <= addr_hit;
          end else if (byte_end) begin
            state <= ISW_ACK;
            O_SDA_OE <= accept;
          end
        end
        ISW_ACK: begin
          if (scl_fall) begin
            state <= ISW_DATA;
            bit_cnt <= 4'h0;
            O_SDA_OE <= 1'b0;
          end
        end
        ISW_IGNORE: begin
          O_SDA_OE <= 1'b0;
        end
        default: begin
          O_SDA_OE <= 1'b0;
        end
      endcase
    end
  end

  // leading byte tracking
  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      armed <= 1'b0;
      armed_op <= 3'h0;
    end else if (start_det || stop_det) begin
      armed <= 1'b0;
    end else if (state == ISW_DATA && byte_end && accept) begin
      if (exec) begin
        armed <= 1'b0;
      end else begin
        armed <= leading;
        armed_op <= rx_cmd.op;
      end
    end
  end

  // ----------------------------------------------------------------
  // command buffer and output register
  // ----------------------------------------------------------------
  logic buf_valid;
  logic [7:0] buf_data;
  logic buf_pop;

  isw_fifo #(.WIDTH(8), .DEPTH(ISW_FIFO_DEPTH)) u_fifo (
    .i_clk(I_CORE_CLK),
    .i_reset_n(I_RESET_N),
    .i_valid(fifo_in_valid),
    .i_data(shreg),
    .o_ready(fifo_in_ready),
    .o_valid(buf_valid),
    .o_data(buf_data),
    .i_ready(buf_pop)
  );

  assign buf_pop = ~O_CMD_VALID | I_CMD_READY;

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_CMD_VALID <= 1'b0;
      O_CMD_DATA <= '0;
    end else if (buf_pop) begin
      O_CMD_VALID <= buf_valid;
      if (buf_valid) begin
        O_CMD_DATA <= isw_cmd_type'(buf_data);
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESET_N);

  property p_start_addr;
    start_det && !stop_det |=> state == ISW_ADDR && bit_cnt == 4'h0;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start did not open address phase");

  property p_ack_match;
    state == ISW_ADDR && byte_end && addr_hit && !start_det && !stop_det |=> O_SDA_OE && state == ISW_ACK;
  endproperty
  a_ack_match: assert property (p_ack_match) else $error("matching address not acknowledged");

  property p_strap_take;
    $rose(strap_done) |-> id_bit_high == $past(ups_s) && id_bit_low == $past(lws_s);
  endproperty
  a_strap_take: assert property (p_strap_take) else $error("straps not taken into address");

  property p_upper_fixed;
    state == ISW_ADDR && byte_end && shreg[7:3] != UPPER_ADDR && !start_det && !stop_det |=> !O_SDA_OE;
  endproperty
  a_upper_fixed: assert property (p_upper_fixed) else $error("upper address bits moved");

  property p_sync_dir;
    strap_done |=> O_OSC_SYNC_OE == id_bit_high;
  endproperty
  a_sync_dir: assert property (p_sync_dir) else $error("sync pin direction wrong");

  property p_data_ack;
    state == ISW_DATA && byte_end && accept && !start_det && !stop_det |=> O_SDA_OE [*4];
  endproperty
  a_data_ack: assert property (p_data_ack) else $error("accepted data byte not acknowledged");

  property p_arm;
    state == ISW_DATA && byte_end && !exec && leading && !start_det && !stop_det
      |=> armed && armed_op == $past(rx_cmd.op);
  endproperty
  a_arm: assert property (p_arm) else $error("leading byte did not arm");

  property p_exec_only_armed;
    fifo_in_valid && fifo_in_ready |-> armed && rx_cmd.op == armed_op ##1 !armed;
  endproperty
  a_exec_only_armed: assert property (p_exec_only_armed) else $error("byte pushed without leading byte");

  property p_stop_idle;
    stop_det |=> state == ISW_IDLE && !O_SDA_OE ##1 !O_SDA_OE;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not return to idle");

  property p_ignore_quiet;
    state == ISW_ADDR && byte_end && !addr_hit && !start_det && !stop_det |=> !O_SDA_OE [*2];
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet) else $error("mismatched address was driven");

  c_addr_ack: cover property (state == ISW_ADDR && byte_end && addr_hit);
  c_push: cover property (fifo_in_valid && fifo_in_ready);
  c_full_nack: cover property (state == ISW_DATA && byte_end && !accept);
  c_ignore: cover property (state == ISW_IGNORE ##1 start_det);

endmodule

// File: sim/isw_master.sv
// bus master model for the two-wire bus, open-drain data with pull-up
`timescale 1ns/1ns
module isw_master (
  // clock
  input wire logic i_clk,
  // bus
  input wire logic i_sda,
  output logic o_scl = 1'b1,
  output logic o_sda_low = 1'b0
);
  // core cycles per quarter of the bus clock, raised for a slow master
  int hc = 2;

  task automatic half();
    repeat (hc) @(posedge i_clk);
  endtask

  // start or repeated start
  task automatic start();
    o_sda_low <= 1'b0;
    half();
    o_scl <= 1'b1;
    half();
    o_sda_low <= 1'b1;
    half();
    o_scl <= 1'b0;
    half();
  endtask

  // one byte msb first, then the acknowledge slot
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      o_sda_low <= ~b[i];
      half();
      o_scl <= 1'b1;
      half();
      half();
      o_scl <= 1'b0;
      half();
    end
    o_sda_low <= 1'b0;
    half();
    o_scl <= 1'b1;
    half();
    ack = ~i_sda;
    half();
    o_scl <= 1'b0;
    half();
  endtask

  task automatic stop();
    o_sda_low <= 1'b1;
    half();
    o_scl <= 1'b1;
    half();
    o_sda_low <= 1'b0;
    half();
  endtask
endmodule

// File: sim/isw_slave_tb.sv
// testbench for the two-wire write-only slave front end
`timescale 1ns/1ns
module isw_slave_tb;
  import isw_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic up_strap = 1'b1;
  logic lo_strap = 1'b0;
  logic sync_in = 1'b0;
  logic cmd_ready = 1'b1;
  logic scl, m_low, sda, sda_out, sda_oe, sync_out, sync_oe, osc_clk, cmd_valid;
  isw_cmd_type cmd_data;
  logic [7:0] got[$];
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;

  // wired data line with pull-up
  assign sda = ~(m_low | (sda_oe & ~sda_out));

  initial begin
    forever #25 clk = ~clk;
  end

  isw_master i_master (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(m_low));

  isw_slave #(.OSC_HALF_CYC(2)) i_dut (
    .I_CORE_CLK(clk), .I_RESET_N(reset_n), .I_SCL(scl), .I_SDA(sda),
    .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .I_UPPER_ID_STRAP(up_strap),
    .I_LOWER_ID_STRAP(lo_strap), .I_OSC_SYNC_IN(sync_in), .O_OSC_SYNC_OUT(sync_out),
    .O_OSC_SYNC_OE(sync_oe), .O_OSC_CLK(osc_clk), .O_CMD_VALID(cmd_valid),
    .O_CMD_DATA(cmd_data), .I_CMD_READY(cmd_ready));

  always @(posedge clk) begin
    if (cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
      got.push_back(cmd_data);
    end
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic do_reset(input logic up, input logic lo);
    reset_n <= 1'b0;
    up_strap <= up;
    lo_strap <= lo;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  function automatic logic [7:0] own(input logic up, input logic lo);
    return {ISW_UPPER_ADDR_DEF, up, lo, ISW_DIR_WRITE};
  endfunction

  // one transfer: address then data, each acknowledge judged
  task automatic frame(input logic [7:0] b[$], input logic e[$]);
    logic a;
    got.delete();
    i_master.start();
    foreach (b[i]) begin
      i_master.put_byte(b[i], a);
      check(a, e[i]);
    end
    i_master.stop();
    repeat (6) @(posedge clk);
    check(sda_oe, 1'b0);
  endtask

  task automatic t_margin();
    logic v;
    logic w;
    do_reset(1'b1, 1'b0);
    check(sync_oe, 1'b1);
    v = osc_clk;
    w = sync_out;
    repeat (2) @(posedge clk);
    check(osc_clk, !v);
    check(sync_out, !w);
    frame('{own(1, 0), 8'h20, 8'h25, 8'h20, 8'h3C}, '{1, 1, 1, 1, 1});
    check(got.size(), 2);
    check(got[0], 8'h25);
    check(got[1], 8'h3C);
    $display("test margin done");
  endtask

  task automatic t_watchdog();
    frame('{own(1, 0), 8'h60, 8'h60, 8'h68, 8'h20, 8'h6B, 8'h60, 8'h6B}, '{1, 1, 1, 1, 1, 1, 1, 1});
    check(got.size(), 2);
    check(got[0], 8'h60);
    check(got[1], 8'h6B);
    $display("test watchdog done");
  endtask

  task automatic t_foreign();
    logic [7:0] bad[4];
    bad = '{own(1, 0) ^ 8'h80, own(1, 0) ^ 8'h02, own(1, 0) ^ 8'h04, own(1, 0) | 8'h01};
    foreach (bad[i]) begin
      frame('{bad[i], 8'h20, 8'h25}, '{0, 0, 0});
      check(got.size(), 0);
    end
    $display("test foreign done");
  endtask

  task automatic t_full();
    cmd_ready <= 1'b0;
    i_master.hc = 4;
    frame('{own(1, 0), 8'h20, 8'h21, 8'h20, 8'h22, 8'h20, 8'h23, 8'h20, 8'h24}, '{1, 1, 1, 1, 1, 1, 1, 1, 0});
    i_master.hc = 2;
    check(cmd_valid, 1'b1);
    cmd_ready <= 1'b1;
    repeat (8) @(posedge clk);
    check(got.size(), 3);
    check(got[0], 8'h21);
    check(got[1], 8'h22);
    check(got[2], 8'h23);
    $display("test full done");
  endtask

  task automatic t_straps();
    do_reset(1'b0, 1'b1);
    check(sync_oe, 1'b0);
    sync_in <= 1'b1;
    repeat (6) @(posedge clk);
    check(osc_clk, 1'b1);
    sync_in <= 1'b0;
    repeat (6) @(posedge clk);
    check(osc_clk, 1'b0);
    frame('{own(1, 0), 8'h60}, '{0, 0});
    frame('{own(0, 1), 8'h60, 8'h60}, '{1, 1, 1});
    check(got[0], 8'h60);
    $display("test straps done");
  endtask

  initial begin
    t_margin();
    t_watchdog();
    t_foreign();
    t_full();
    t_straps();
    report_and_stop();
  end
endmodule
